// ==== hw/bkrcfg_pkg.sv ====
// package: register map, field layouts, reset values and timing of the buck config/status bank
package bkrcfg_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // register offsets
  localparam logic [7:0] OFS_OT_FAULT_RESP   = 8'h50;
  localparam logic [7:0] OFS_OVERTEMP_WARN_LIMIT   = 8'h51;
  localparam logic [7:0] OFS_VIN_OV_LIMIT    = 8'h55;
  localparam logic [7:0] OFS_TON_DLY         = 8'h60;
  localparam logic [7:0] OFS_SS_TIME         = 8'h61;
  localparam logic [7:0] OFS_TOFF_DLY        = 8'h64;
  localparam logic [7:0] OFS_STOP_TIME       = 8'h65;
  localparam logic [7:0] OFS_PIN_WARN_LIMIT  = 8'h6B;
  localparam logic [7:0] OFS_STAT_VOUT       = 8'h7A;
  localparam logic [7:0] OFS_STAT_IOUT       = 8'h7B;
  localparam logic [7:0] OFS_STAT_INPUT      = 8'h7C;
  localparam logic [7:0] OFS_STAT_TEMP       = 8'h7D;
  localparam logic [7:0] OFS_STAT_VENDOR     = 8'h80;
  localparam logic [7:0] OFS_RD_VIN          = 8'h88;
  localparam logic [7:0] OFS_RD_IIN          = 8'h89;
  localparam logic [7:0] OFS_RD_VOUT         = 8'h8B;
  localparam logic [7:0] OFS_RD_IOUT         = 8'h8C;
  localparam logic [7:0] OFS_RD_TEMP         = 8'h8D;
  localparam logic [7:0] OFS_RD_PIN          = 8'h97;
  localparam logic [7:0] OFS_SYS_CFG         = 8'hA0;
  localparam logic [7:0] OFS_HOST_ADDR       = 8'hA2;
  localparam logic [7:0] OFS_VBUS_ADDR       = 8'hA3;
  localparam logic [7:0] OFS_IOUT_CAL        = 8'hA4;
  localparam logic [7:0] OFS_INPUT_CURRENT_CALIBRATION         = 8'hA5;
  localparam logic [7:0] OFS_VOUT_SET        = 8'hA6;
  localparam logic [7:0] OFS_LAST_VCMD       = 8'hA7;
  localparam logic [7:0] OFS_HOST_VOFS       = 8'hA8;
  localparam logic [7:0] OFS_COMP_A          = 8'hA9;
  localparam logic [7:0] OFS_COMP_B          = 8'hAA;
  localparam logic [7:0] OFS_ONOFF_CFG       = 8'h02;
  localparam logic [7:0] OFS_STORE_ALL       = 8'h15;

  // reset values
  localparam logic [7:0] RST_OT_FAULT_RESP   = 8'h00;
  localparam logic [7:0] RST_OVERTEMP_WARN_LIMIT   = 8'h06;
  localparam logic [7:0] RST_VIN_OV_LIMIT    = 8'h01;
  localparam logic [7:0] RST_TIMING          = 8'h00;
  localparam logic [7:0] RST_PIN_WARN_LIMIT  = 8'h03;
  localparam logic [7:0] RST_SYS_CFG         = 8'h10;
  localparam logic [7:0] RST_HOST_ADDR       = 8'h77;
  localparam logic [7:0] RST_VBUS_ADDR       = 8'h00;
  localparam logic [7:0] RST_CAL             = 8'h78;
  localparam logic [7:0] RST_VOUT_SET        = 8'hAB;
  localparam logic [7:0] RST_HOST_VOFS       = 8'h00;
  localparam logic [7:0] RST_COMP_A          = 8'h4A;
  localparam logic [7:0] RST_COMP_B          = 8'h19;
  localparam logic [7:0] RST_ONOFF_CFG       = 8'h40;
  localparam logic [7:0] ZERO_BYTE           = 8'h00;

  // field layouts
  localparam int unsigned SYS_SRC_LSB        = 2;   // output control source, 2 bits
  localparam int unsigned SYS_SOFTSTOP_BIT   = 4;   // soft-stop enable
  localparam logic [1:0]  SRC_HOST_A         = 2'h2;
  localparam logic [1:0]  SRC_HOST_B         = 2'h3;
  localparam logic [7:0]  ADDR_FIELD_MASK    = 8'h7F;
  localparam logic [7:0]  OT_RESP_LATCH      = 8'h00;
  localparam int unsigned ONOFF_PIN_BIT      = 6;   // enable pin acts as start/stop
  localparam int unsigned TIME_SEL_W         = 2;   // timing code field in low bits
  localparam logic [1:0]  STRAP_SYNC_EDGES   = 2'h2; // edges until the strap sync chain holds the pin value

  // timing base figures in microseconds and their equivalents in clock cycles
  localparam int unsigned TON_DLY_BASE_US    = 500;
  localparam int unsigned SS_BASE_US         = 1000;
  localparam int unsigned TOFF_DLY_STEP_US   = 500;
  localparam int unsigned STOP_BASE_US       = 500;
  localparam int unsigned US_CYC             = CLK_HZ / 1_000_000;
  localparam int unsigned TON_DLY_BASE_CYC   = TON_DLY_BASE_US * US_CYC;
  localparam int unsigned SS_BASE_CYC        = SS_BASE_US * US_CYC;
  localparam int unsigned TOFF_DLY_STEP_CYC  = TOFF_DLY_STEP_US * US_CYC;
  localparam int unsigned STOP_BASE_CYC      = STOP_BASE_US * US_CYC;

  typedef enum logic [2:0] {
    SEQ_OFF      = 3'h0,
    SEQ_ON_DLY   = 3'h1,
    SEQ_RISE     = 3'h2,
    SEQ_REG      = 3'h3,
    SEQ_OFF_DLY  = 3'h4,
    SEQ_FALL     = 3'h5,
    SEQ_LATCHED  = 3'h6
  } bkrcfg_seq_type;

  // telemetry samples from the converters
  typedef struct packed {
    logic [7:0] vin;
    logic [7:0] iin;
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] temp;
  } bkrcfg_telem_type;

  // protection and status inputs
  typedef struct packed {
    logic [7:0] stat_vout;
    logic [7:0] stat_iout;
    logic [7:0] stat_input;
    logic [7:0] stat_temp;
    logic [7:0] stat_vendor;
    logic       ot_fault;
  } bkrcfg_prot_type;

  // register bank write/read port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bkrcfg_req_type;

endpackage : bkrcfg_pkg

// ==== hw/bkrcfg_bank.sv ====
// module: buck regulator configuration, limit, sequencing and telemetry register bank
//
// Overview of operation
// - after start condition, wait programmed turn-on delay (default 0.5 ms) before rising.
// - ramp output into regulation over programmed soft-start time, default 1 ms.
// - after stop condition, wait programmed turn-off delay (default 0 ms) before soft-stop.
// - after turn-off delay, ramp reference DAC to zero over fall time, default 0.5 ms.
// - stored setpoint applies only when output control source field is 10b or 11b.
// - last output voltage command, from either bus, is readable read-only.
// - address register stored 77h; strap-decoded address takes effect and reads back; bit 7 reserved.
// - input power reading is the high byte of measured input voltage times measured input current.
// - system configuration resets to 10h: light-load discontinuous, voltage-bus control, soft-stop on.
// - overtemperature fault response 00h latches the output off after a fault.
// - overtemperature warning flags at programmed threshold, default code 06h.
// - input overvoltage fault detected at programmed threshold, default code 01h.
// - input overpower warning when input power exceeds limit, default code 03h.
// - both current calibration registers reset to 78h, zero gain and offset correction.
// - stored output setpoint resets to ABh, readable and writable, nonvolatile-backed.
// - voltage-bus device address is readable, writable, nonvolatile-backed, resets to 00h.
// - input voltage reading is read-only and returns negative input sense pin measurement.
// - second compensation register resets to 19h.
// - on/off configuration resets to 40h: enable pin alone starts and stops.
// - store command copies all storable settings into nonvolatile memory.
`timescale 1ns/1ps

module bkrcfg_bank
  import bkrcfg_pkg::*;
#(
  parameter int unsigned CNT_W = 20
)
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  input  wire bkrcfg_pkg::bkrcfg_req_type   req,
  input  wire bkrcfg_pkg::bkrcfg_telem_type telem,
  input  wire bkrcfg_pkg::bkrcfg_prot_type  prot,
  input  wire logic                         enable_pin,
  input  wire logic [6:0]                   strap_addr,
  input  wire logic                         vbus_cmd_valid,
  input  wire logic [7:0]                   vbus_cmd,
  output logic [7:0]                        rdata,
  output logic                              store_pulse,
  output logic [7:0]                        ref_dac,
  output logic                              output_enabled,
  output logic                              ot_warning,
  output logic                              vin_ov_fault,
  output logic                              pin_op_warning,
  output logic [6:0]                        host_addr_active
);
  import bkrcfg_pkg::*;

  if (CNT_W < 18 || CNT_W > 31)
  begin : g_bad_cnt_w
    $error("CNT_W must hold the longest timing count");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]     en_sync;
    logic [6:0]     strap_q1;
    logic [6:0]     strap_q2;
    logic           strap_done;
    logic [1:0]     strap_cnt;
    logic [7:0]     ot_resp;
    logic [7:0]     ot_warn_lim;
    logic [7:0]     vin_ov_lim;
    logic [7:0]     ton_dly;
    logic [7:0]     ss_time;
    logic [7:0]     toff_dly;
    logic [7:0]     stop_time;
    logic [7:0]     pin_warn_lim;
    logic [7:0]     sys_cfg;
    logic [7:0]     host_addr;
    logic [7:0]     vbus_addr;
    logic [7:0]     iout_cal;
    logic [7:0]     input_current_calibration;
    logic [7:0]     vout_set;
    logic [7:0]     last_vcmd;
    logic [7:0]     host_vofs;
    logic [7:0]     comp_a;
    logic [7:0]     comp_b;
    logic [7:0]     onoff_cfg;
    logic [7:0]     pin_prod;
    bkrcfg_seq_type seq;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] span;
    logic [7:0]     ref_dac;
    logic [7:0]     ref_from;
    logic [7:0]     rdata;
    logic           store_pulse;
    logic           ot_warning;
    logic           vin_ov_fault;
    logic           pin_op_warning;
    logic           output_enabled;
  } bkrcfg_state_type;

  bkrcfg_state_type state;
  bkrcfg_state_type next_state;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // timing codes select multiples of the base step; code 0 is the default figure
  function automatic logic [CNT_W-1:0] span_of(input logic [7:0] code, input int unsigned base);
    logic [CNT_W-1:0] step;
    step = CNT_W'(base);
    return step << code[TIME_SEL_W-1:0];
  endfunction : span_of

  // linear ramp point between two levels at count c of total s
  function automatic logic [7:0] ramp(input logic [7:0] from, input logic [7:0] to,
                                      input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] s);
    logic [CNT_W+8:0] acc;
    acc = '0;
    if (s != '0)
      acc = (CNT_W+9)'((CNT_W+9)'(to) * (CNT_W+9)'(c) / (CNT_W+9)'(s))
          + (CNT_W+9)'((CNT_W+9)'(from) * (CNT_W+9)'(s - c) / (CNT_W+9)'(s));
    return acc[7:0];
  endfunction : ramp

  logic [7:0]  target;
  logic [1:0]  src;
  logic        run_req;
  logic [15:0] prod;
  logic [7:0]  wd;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    wd         = req.wdata;
    src        = state.sys_cfg[SYS_SRC_LSB +: 2];

    if (clk_en)
    begin
      next_state.store_pulse = 1'b0;
      next_state.en_sync  = {state.en_sync[0], enable_pin};
      next_state.strap_q1 = strap_addr;
      next_state.strap_q2 = state.strap_q1;
      // the strap is trusted only once both sync stages hold it, not the reset zeros
      if (!state.strap_done && state.strap_cnt == STRAP_SYNC_EDGES)
      begin
        next_state.host_addr  = {1'b0, state.strap_q2};
        next_state.strap_done = 1'b1;
      end
      else if (!state.strap_done)
        next_state.strap_cnt = state.strap_cnt + 2'h1;

      prod = 16'(telem.vin) * 16'(telem.iin);
      next_state.pin_prod       = prod[15:8];
      next_state.ot_warning     = telem.temp >= state.ot_warn_lim;
      next_state.vin_ov_fault   = telem.vin >= state.vin_ov_lim;
      next_state.pin_op_warning = state.pin_prod > state.pin_warn_lim;

      if (vbus_cmd_valid)
        next_state.last_vcmd = vbus_cmd;

      if (req.wr)
      begin
        unique case (req.addr)
          OFS_OT_FAULT_RESP:  next_state.ot_resp      = wd;
          OFS_OVERTEMP_WARN_LIMIT:  next_state.ot_warn_lim  = wd;
          OFS_VIN_OV_LIMIT:   next_state.vin_ov_lim   = wd;
          OFS_TON_DLY:        next_state.ton_dly      = wd;
          OFS_SS_TIME:        next_state.ss_time      = wd;
          OFS_TOFF_DLY:       next_state.toff_dly     = wd;
          OFS_STOP_TIME:      next_state.stop_time    = wd;
          OFS_PIN_WARN_LIMIT: next_state.pin_warn_lim = wd;
          OFS_SYS_CFG:        next_state.sys_cfg      = wd;
          OFS_HOST_ADDR:      next_state.host_addr    = wd & ADDR_FIELD_MASK;
          OFS_VBUS_ADDR:      next_state.vbus_addr    = wd;
          OFS_IOUT_CAL:       next_state.iout_cal     = wd;
          OFS_INPUT_CURRENT_CALIBRATION:        next_state.input_current_calibration      = wd;
          OFS_VOUT_SET:
          begin
            next_state.vout_set = wd;
            if (src == SRC_HOST_A || src == SRC_HOST_B)
              next_state.last_vcmd = wd;
          end
          OFS_HOST_VOFS:      next_state.host_vofs    = wd;
          OFS_COMP_A:         next_state.comp_a       = wd;
          OFS_COMP_B:         next_state.comp_b       = wd;
          OFS_ONOFF_CFG:      next_state.onoff_cfg    = wd;
          OFS_STORE_ALL:      next_state.store_pulse  = 1'b1;
          default:            next_state.store_pulse  = 1'b0;
        endcase
      end

      next_state.rdata = ZERO_BYTE;
      if (req.rd)
      begin
        unique case (req.addr)
          OFS_OT_FAULT_RESP:  next_state.rdata = state.ot_resp;
          OFS_OVERTEMP_WARN_LIMIT:  next_state.rdata = state.ot_warn_lim;
          OFS_VIN_OV_LIMIT:   next_state.rdata = state.vin_ov_lim;
          OFS_TON_DLY:        next_state.rdata = state.ton_dly;
          OFS_SS_TIME:        next_state.rdata = state.ss_time;
          OFS_TOFF_DLY:       next_state.rdata = state.toff_dly;
          OFS_STOP_TIME:      next_state.rdata = state.stop_time;
          OFS_PIN_WARN_LIMIT: next_state.rdata = state.pin_warn_lim;
          OFS_STAT_VOUT:      next_state.rdata = prot.stat_vout;
          OFS_STAT_IOUT:      next_state.rdata = prot.stat_iout;
          OFS_STAT_INPUT:     next_state.rdata = prot.stat_input;
          OFS_STAT_TEMP:      next_state.rdata = prot.stat_temp;
          OFS_STAT_VENDOR:    next_state.rdata = prot.stat_vendor;
          OFS_RD_VIN:         next_state.rdata = telem.vin;
          OFS_RD_IIN:         next_state.rdata = telem.iin;
          OFS_RD_VOUT:        next_state.rdata = telem.vout;
          OFS_RD_IOUT:        next_state.rdata = telem.iout;
          OFS_RD_TEMP:        next_state.rdata = telem.temp;
          OFS_RD_PIN:         next_state.rdata = state.pin_prod;
          OFS_SYS_CFG:        next_state.rdata = state.sys_cfg;
          OFS_HOST_ADDR:      next_state.rdata = state.host_addr;
          OFS_VBUS_ADDR:      next_state.rdata = state.vbus_addr;
          OFS_IOUT_CAL:       next_state.rdata = state.iout_cal;
          OFS_INPUT_CURRENT_CALIBRATION:        next_state.rdata = state.input_current_calibration;
          OFS_VOUT_SET:       next_state.rdata = state.vout_set;
          OFS_LAST_VCMD:      next_state.rdata = state.last_vcmd;
          OFS_HOST_VOFS:      next_state.rdata = state.host_vofs;
          OFS_COMP_A:         next_state.rdata = state.comp_a;
          OFS_COMP_B:         next_state.rdata = state.comp_b;
          OFS_ONOFF_CFG:      next_state.rdata = state.onoff_cfg;
          default:            next_state.rdata = ZERO_BYTE;
        endcase
      end

      // setpoint source: host setpoint only under host control, else the voltage bus
      target = (src == SRC_HOST_A || src == SRC_HOST_B) ? state.vout_set
                                                         : state.last_vcmd;
      // enable pin alone governs start and stop while its bit is set
      run_req = state.onoff_cfg[ONOFF_PIN_BIT] ? state.en_sync[1] : 1'b1;

      next_state.cnt = state.cnt + CNT_W'(1);
      unique case (state.seq)
        SEQ_OFF:
        begin
          next_state.ref_dac = ZERO_BYTE;
          if (run_req)
          begin
            next_state.seq  = SEQ_ON_DLY;
            next_state.cnt  = '0;
            next_state.span = span_of(state.ton_dly, TON_DLY_BASE_CYC);
          end
        end
        SEQ_ON_DLY:
          if (!run_req)
            next_state.seq = SEQ_OFF;
          else if (state.cnt + CNT_W'(1) >= state.span)
          begin
            next_state.seq      = SEQ_RISE;
            next_state.cnt      = '0;
            next_state.ref_from = ZERO_BYTE;
            next_state.span     = span_of(state.ss_time, SS_BASE_CYC);
          end
        SEQ_RISE:
        begin
          next_state.ref_dac = ramp(state.ref_from, target, state.cnt, state.span);
          if (state.cnt + CNT_W'(1) >= state.span)
          begin
            next_state.seq     = SEQ_REG;
            next_state.ref_dac = target;
          end
        end
        SEQ_REG:
        begin
          next_state.ref_dac = target;
          if (!run_req)
          begin
            next_state.seq  = SEQ_OFF_DLY;
            next_state.cnt  = '0;
            // zero code means no delay at all
            next_state.span = CNT_W'(state.toff_dly[TIME_SEL_W-1:0]) * CNT_W'(TOFF_DLY_STEP_CYC);
          end
        end
        SEQ_OFF_DLY:
          if (state.cnt >= state.span)
          begin
            next_state.cnt      = '0;
            next_state.ref_from = state.ref_dac;
            next_state.span     = span_of(state.stop_time, STOP_BASE_CYC);
            next_state.seq      = state.sys_cfg[SYS_SOFTSTOP_BIT] ? SEQ_FALL : SEQ_OFF;
          end
        SEQ_FALL:
        begin
          next_state.ref_dac = ramp(state.ref_from, ZERO_BYTE, state.cnt, state.span);
          if (state.cnt + CNT_W'(1) >= state.span)
          begin
            next_state.seq     = SEQ_OFF;
            next_state.ref_dac = ZERO_BYTE;
          end
        end
        SEQ_LATCHED:
          next_state.ref_dac = ZERO_BYTE;
        default:
          next_state.seq = SEQ_OFF;
      endcase

      // latch-off dominates every sequencing phase until reset
      if (prot.ot_fault && state.ot_resp == OT_RESP_LATCH)
      begin
        next_state.seq     = SEQ_LATCHED;
        next_state.ref_dac = ZERO_BYTE;
      end
      next_state.output_enabled = next_state.seq != SEQ_OFF && next_state.seq != SEQ_LATCHED;
    end
    else
    begin
      target  = ZERO_BYTE;
      run_req = 1'b0;
      prod    = '0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state              <= '0;
      state.seq          <= SEQ_OFF;
      state.ot_resp      <= RST_OT_FAULT_RESP;
      state.ot_warn_lim  <= RST_OVERTEMP_WARN_LIMIT;
      state.vin_ov_lim   <= RST_VIN_OV_LIMIT;
      state.ton_dly      <= RST_TIMING;
      state.ss_time      <= RST_TIMING;
      state.toff_dly     <= RST_TIMING;
      state.stop_time    <= RST_TIMING;
      state.pin_warn_lim <= RST_PIN_WARN_LIMIT;
      state.sys_cfg      <= RST_SYS_CFG;
      state.host_addr    <= RST_HOST_ADDR;
      state.vbus_addr    <= RST_VBUS_ADDR;
      state.iout_cal     <= RST_CAL;
      state.input_current_calibration      <= RST_CAL;
      state.vout_set     <= RST_VOUT_SET;
      state.host_vofs    <= RST_HOST_VOFS;
      state.comp_a       <= RST_COMP_A;
      state.comp_b       <= RST_COMP_B;
      state.onoff_cfg    <= RST_ONOFF_CFG;
    end
    else
      state <= next_state;
  end

  assign rdata            = state.rdata;
  assign store_pulse      = state.store_pulse;
  assign ref_dac          = state.ref_dac;
  assign output_enabled   = state.output_enabled;
  assign ot_warning       = state.ot_warning;
  assign vin_ov_fault     = state.vin_ov_fault;
  assign pin_op_warning   = state.pin_op_warning;
  assign host_addr_active = state.host_addr[6:0];

endmodule : bkrcfg_bank

// ==== tb/bkrcfg_bank_monitor.sv ====
// checker: port-level assertions of the config/status bank
`timescale 1ns/1ps
module bkrcfg_bank_monitor
  import bkrcfg_pkg::*;
(
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire bkrcfg_pkg::bkrcfg_req_type   req,
  input wire bkrcfg_pkg::bkrcfg_telem_type telem,
  input wire bkrcfg_pkg::bkrcfg_prot_type  prot,
  input wire logic [7:0]                   rdata,
  input wire logic                         store_pulse,
  input wire logic [7:0]                   ref_dac,
  input wire logic                         output_enabled
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // cycles since enable, to time the start of the rise
  logic [15:0] on_cnt;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      on_cnt <= '0;
    else
      on_cnt <= output_enabled ? on_cnt + 16'h1 : '0;
  a_store_pulse: assert property (req.wr && req.addr == OFS_STORE_ALL |=> store_pulse)
    else $error("store pulse missing");
  a_store_only: assert property (store_pulse |-> $past(req.wr && req.addr == OFS_STORE_ALL))
    else $error("stray store pulse");
  a_rdata_idle: assert property (!req.rd |=> rdata == ZERO_BYTE)
    else $error("read data not cleared");
  a_vin_read: assert property (req.rd && req.addr == OFS_RD_VIN |=> rdata == $past(telem.vin))
    else $error("bad voltage read");
  a_pin_read: assert property (req.rd && req.addr == OFS_RD_PIN
    |=> rdata == 8'((16'(telem.vin) * 16'(telem.iin)) >> 8)) else $error("bad power read");
  a_rise_hold: assert property ($rose(output_enabled) |-> ref_dac == ZERO_BYTE [*8])
    else $error("early rise");
  a_rise_delay: assert property (output_enabled && ref_dac != 8'h00 && $past(ref_dac) == 8'h00
    |-> on_cnt inside {[16'd4990:16'd5100]}) else $error("rise off delay");
  a_ot_latch: assert property (prot.ot_fault && output_enabled
    |-> ##[1:4] !output_enabled ##1 !output_enabled [*8]) else $error("no latch-off");
endmodule : bkrcfg_bank_monitor

bind bkrcfg_bank bkrcfg_bank_monitor bkrcfg_bank_monitor_i (.clk, .rst_n, .req, .telem, .prot, .rdata,
  .store_pulse, .ref_dac, .output_enabled);

// ==== tb/bkrcfg_vbus_master.sv ====
// partner: voltage-bus master issuing one command per request
`timescale 1ns/1ps
module bkrcfg_vbus_master
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] code,
  output logic            valid,
  output logic [7:0]      cmd
);
  initial valid = 1'b0;
  initial cmd = 8'h00;
  // idle data toggles so a decoder ignoring valid is caught
  always @(negedge clk)
  begin
    valid <= go;
    cmd   <= go ? code : ~cmd;
  end
endmodule : bkrcfg_vbus_master

// ==== tb/bkrcfg_bank_tb.sv ====
// testbench: bank registers, voltage commands and sequencing
`timescale 1ns/1ps
module bkrcfg_bank_tb;
  import bkrcfg_pkg::*;
  logic             clk = 1'b0, rst_n = 1'b0, en = 1'b0, go = 1'b0, rd_q = 1'b0, vv, oe, sp, otw, ovf, opw;
  logic [7:0]       code = 8'h00, rdata, ref_dac, vc, d;
  logic [6:0]       strap, haa;
  bkrcfg_req_type   req = '0;
  bkrcfg_telem_type telem;
  bkrcfg_prot_type  prot = '0;
  logic [7:0]       expq[$];
  int               mismatches = 0, n_compared = 0, stores = 0, cyc = 0;
  logic [15:0]      tbl[16] = '{16'h5000, 16'h5106, 16'h5501, 16'h6000, 16'h6100, 16'h6400, 16'h6500,
    16'h6B03, 16'hA010, 16'hA300, 16'hA478, 16'hA578, 16'hA6AB, 16'hA94A, 16'hAA19, 16'h0240};
  always #50 clk = ~clk;
  bkrcfg_bank bkrcfg_bank_i (.clk, .rst_n, .clk_en(1'b1), .req, .telem, .prot, .enable_pin(en),
    .strap_addr(strap), .vbus_cmd_valid(vv), .vbus_cmd(vc), .rdata, .store_pulse(sp), .ref_dac,
    .output_enabled(oe), .ot_warning(otw), .vin_ov_fault(ovf), .pin_op_warning(opw), .host_addr_active(haa));
  bkrcfg_vbus_master bkrcfg_vbus_master_i (.clk, .go, .code, .valid(vv), .cmd(vc));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // a read notes its expected byte; the watcher below compares it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    if (!w)
      expq.push_back(v);
    @(negedge clk);
    req <= '{w, !w, a, w ? v : 8'h00};
    @(negedge clk);
    req <= '0;
  endtask : acc
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  always @(posedge clk)
  begin
    if (rd_q)
      check(rdata, expq.pop_front());
    rd_q = req.rd;
    if (sp === 1'b1)
      stores++;
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    void'($urandom(32'hCA9D));
    strap = 7'($urandom);
    telem = {8'($urandom), 8'($urandom), 16'h0000, 8'($urandom)};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    foreach (tbl[i])
      acc(1'b0, tbl[i][15:8], tbl[i][7:0]);
    for (int i = 9; i < 15; i++)
    begin
      d = 8'($urandom);
      acc(1'b1, tbl[i][15:8], d);
      acc(1'b0, tbl[i][15:8], d);
    end
    acc(1'b1, OFS_RD_VIN, ~telem.vin);
    acc(1'b0, OFS_RD_VIN, telem.vin);
    acc(1'b0, OFS_RD_PIN, 8'((16'(telem.vin) * 16'(telem.iin)) >> 8));
    acc(1'b0, OFS_HOST_ADDR, {1'b0, strap});
    acc(1'b0, 8'hFF, 8'h00);
    acc(1'b1, OFS_STORE_ALL, 8'h00);
    acc(1'b1, OFS_STORE_ALL, 8'h00);
    code <= 8'($urandom) | 8'h80;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (3) @(negedge clk);
    acc(1'b0, OFS_LAST_VCMD, code);
    en <= 1'b1;
    repeat (4900) @(negedge clk);
    check(ref_dac, 8'h00);
    repeat (10300) @(negedge clk);
    check(ref_dac, code);
    d = 8'($urandom) | 8'h80;
    acc(1'b1, OFS_VOUT_SET, d);
    repeat (200) @(negedge clk);
    check(ref_dac, code);
    acc(1'b1, OFS_SYS_CFG, 8'h18);
    repeat (200) @(negedge clk);
    check(ref_dac, d);
    en <= 1'b0;
    repeat (4000) @(negedge clk);
    check(8'(ref_dac == 8'h00), 8'h00);
    repeat (1300) @(negedge clk);
    check(ref_dac, 8'h00);
    check(8'(oe), 8'h00);
    en <= 1'b1;
    repeat (100) @(negedge clk);
    prot.ot_fault <= 1'b1;
    repeat (10) @(negedge clk);
    prot.ot_fault <= 1'b0;
    repeat (10) @(negedge clk);
    check(8'(oe), 8'h00);
    check(8'(stores), 8'h02);
    // just below the default limits: temp 05h, vin 00h, power (00h*40h)>>8 = 0
    telem <= {8'h00, 8'h40, 16'h0000, 8'h05};
    repeat (3) @(negedge clk);
    check(8'(otw), 8'h00);
    check(8'(ovf), 8'h00);
    check(8'(opw), 8'h00);
    // at or above them: temp 06h, vin 10h, power (10h*40h)>>8 = 4 > 3
    telem <= {8'h10, 8'h40, 16'h0000, 8'h06};
    repeat (3) @(negedge clk);
    check(8'(otw), 8'h01);
    check(8'(ovf), 8'h01);
    check(8'(opw), 8'h01);
    check(8'(haa), 8'(strap));
    final_report();
  end
endmodule : bkrcfg_bank_tb
